// ---- src/rttr_defs.svh ----
// Constants of the retire trace and trap report block.
`ifndef RTTR_DEFS_SVH
`define RTTR_DEFS_SVH

// ----------------------------------------------------------------
// Widths
// ----------------------------------------------------------------
`define RTTR_LANES 2
`define RTTR_TRAP_W 14
`define RTTR_ORDER_W 64
`define RTTR_PC_W 32

// ----------------------------------------------------------------
// Trap record fields
// ----------------------------------------------------------------
`define RTTR_F_TRAP 0
`define RTTR_F_EXC 1
`define RTTR_F_DBG 2
`define RTTR_F_CODE_LO 3
`define RTTR_F_CODE_HI 8
`define RTTR_F_DCAUSE_LO 9
`define RTTR_F_DCAUSE_HI 11
`define RTTR_F_SUB_LO 12
`define RTTR_F_SUB_HI 13

// ----------------------------------------------------------------
// Exception codes, debug causes and fault subtypes
// ----------------------------------------------------------------
`define RTTR_EC_FETCH_ACCESS 6'h01
`define RTTR_EC_ILLEGAL 6'h02
`define RTTR_EC_BREAKPOINT 6'h03
`define RTTR_EC_LOAD_ACCESS 6'h05
`define RTTR_EC_STORE_ACCESS 6'h07
`define RTTR_EC_ECALL_USER 6'h08
`define RTTR_EC_ECALL_MACHINE 6'h0b
`define RTTR_EC_FETCH_BUS 6'h24
`define RTTR_EC_FETCH_INTEGRITY 6'h25
`define RTTR_DC_NONE 3'h0
`define RTTR_DC_EBREAK 3'h1
`define RTTR_DC_TRIGGER 3'h2
`define RTTR_DC_STEP 3'h4
`define RTTR_SUB_0 2'h0
`define RTTR_SUB_1 2'h1
`define RTTR_SUB_2 2'h2

// ----------------------------------------------------------------
// Register offsets and reset values
// ----------------------------------------------------------------
`define RTTR_A_CTRL 8'h00
`define RTTR_A_ORDER_LO 8'h04
`define RTTR_A_ORDER_HI 8'h08
`define RTTR_A_TRAP_CAUSE 8'h0c
`define RTTR_A_TRAP_PC 8'h10
`define RTTR_A_DEBUG_PC 8'h14
`define RTTR_A_DEBUG_STATUS 8'h18
`define RTTR_A_LAST_TRAP 8'h1c
`define RTTR_CTRL_RESET 2'h0
`define RTTR_CTRL_EBM 0
`define RTTR_CTRL_EBU 1

`endif

// ---- src/rttr_pkg.sv ----
// Types shared by the retire trace and trap report block.
package rttr_pkg;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef logic [13:0] rttr_trap_t;

  typedef enum logic [1:0] {
    RTTR_KIND_NONE,
    RTTR_KIND_EXC,
    RTTR_KIND_DEBUG,
    RTTR_KIND_DEBUG_STAY
  } rttr_kind_e;

endpackage : rttr_pkg

// ---- src/rttr_top.sv ----
// Retire trace and trap report: records, order count, trap side effects, registers.
//
// Function
// - Trace outputs besides the valid strobe mean something only while valid is high.
// - Each retired or trapping instruction raises valid and advances the order count.
// - Trace outputs are don't-care while valid is low; the consumer ignores them.
// - Record is 14 bits: trap, exception, debug, code[8:3], cause[11:9], subtype[13:12].
// - Trap flag set for any exception or debug entry.
// - Exception flag for traps with an exception code, debug flag for traps with debug entry.
// - Code describes exceptions, cause describes debug entries, subtype splits same codes.
// - Single step gives debug cause 4; with an exception both flags set.
// - Side effects and handler jump follow a reported trap in the next cycle.
// - Fetch from non-executable memory: code 0x01 subtype 0, updates cause and pc.
// - Fetch failing protection check: code 0x01 subtype 1.
// - Illegal gives 0x02, breakpoint without debug gives 0x03, subtype zero.
// - Load access fault: subtype 0 for misaligned I/O, 2 for protection failure.
// - Store access fault code 0x07: subtype 0 misaligned I/O, 2 protection.
// - User-mode environment call gives 0x08 subtype zero, updates cause and pc.
// - Fetch bus error gives code 0x24 subtype zero.
// - Fetch parity or checksum failure gives code 0x25 subtype zero.
// - Breakpoint outside debug with debug-on-breakpoint: debug cause 1, updates debug csrs.
// - Breakpoint inside debug mode: debug trap cause 1, only the last trap register updated.
// - Before-execution trigger match: debug cause 2, updates debug pc and status.
`include "rttr_defs.svh"

module rttr_top (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic in_debug,
  input wire logic user_mode,
  input wire logic step_enable,
  input wire logic [`RTTR_LANES-1:0] lane_retire,
  input wire logic [`RTTR_LANES*`RTTR_PC_W-1:0] lane_pc,
  input wire logic [`RTTR_LANES-1:0] ev_fetch_pma,
  input wire logic [`RTTR_LANES-1:0] ev_fetch_pmp,
  input wire logic [`RTTR_LANES-1:0] ev_fetch_bus,
  input wire logic [`RTTR_LANES-1:0] ev_fetch_integrity,
  input wire logic [`RTTR_LANES-1:0] ev_illegal,
  input wire logic [`RTTR_LANES-1:0] ev_ebreak,
  input wire logic [`RTTR_LANES-1:0] ev_ecall,
  input wire logic [`RTTR_LANES-1:0] ev_load_io,
  input wire logic [`RTTR_LANES-1:0] ev_load_pmp,
  input wire logic [`RTTR_LANES-1:0] ev_store_io,
  input wire logic [`RTTR_LANES-1:0] ev_store_pmp,
  input wire logic [`RTTR_LANES-1:0] ev_trigger,
  output logic [`RTTR_LANES-1:0] trace_valid,
  output logic [`RTTR_LANES*`RTTR_ORDER_W-1:0] trace_order,
  output logic [`RTTR_LANES*`RTTR_TRAP_W-1:0] trace_trap,
  output logic [`RTTR_LANES*`RTTR_PC_W-1:0] trace_pc,
  output logic trap_csr_wr,
  output logic debug_csr_wr,
  output logic jump_trap_handler,
  output logic jump_debug_handler
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] offset);
    reg_hit = (addr == offset);
  endfunction : reg_hit

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  logic [1:0] ctrl;
  logic ebreak_to_debug;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= `RTTR_CTRL_RESET;
    end else if (reg_wr && reg_hit(reg_addr, `RTTR_A_CTRL)) begin
      ctrl <= reg_wdata[1:0];
    end
  end

  // The breakpoint control that applies depends on the privilege of the instruction.
  assign ebreak_to_debug = user_mode ? ctrl[`RTTR_CTRL_EBU] : ctrl[`RTTR_CTRL_EBM];

  // ----------------------------------------------------------------
  // Per-lane trap encoding
  // ----------------------------------------------------------------
  rttr_pkg::rttr_trap_t lane_trap [`RTTR_LANES];
  rttr_pkg::rttr_kind_e lane_kind [`RTTR_LANES];
  logic [`RTTR_LANES-1:0] lane_upd_trap;
  logic [`RTTR_LANES-1:0] lane_upd_debug;

  genvar g;
  generate
    for (g = 0; g < `RTTR_LANES; g++) begin : g_lane
      rttr_trap_encode u_enc (
        .in_debug(in_debug),
        .user_mode(user_mode),
        .ebreak_to_debug(ebreak_to_debug),
        .step_enable(step_enable),
        .ev_fetch_pma(ev_fetch_pma[g]),
        .ev_fetch_pmp(ev_fetch_pmp[g]),
        .ev_fetch_bus(ev_fetch_bus[g]),
        .ev_fetch_integrity(ev_fetch_integrity[g]),
        .ev_illegal(ev_illegal[g]),
        .ev_ebreak(ev_ebreak[g]),
        .ev_ecall(ev_ecall[g]),
        .ev_load_io(ev_load_io[g]),
        .ev_load_pmp(ev_load_pmp[g]),
        .ev_store_io(ev_store_io[g]),
        .ev_store_pmp(ev_store_pmp[g]),
        .ev_trigger(ev_trigger[g]),
        .trap(lane_trap[g]),
        .kind(lane_kind[g]),
        .upd_trap_csr(lane_upd_trap[g]),
        .upd_debug_csr(lane_upd_debug[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Record selection and order numbering
  // ----------------------------------------------------------------
  // A trap redirects the core, so younger lanes in the same cycle are
  // squashed rather than reported after it.
  logic [`RTTR_ORDER_W-1:0] order;
  logic [`RTTR_ORDER_W-1:0] next_order;
  logic [`RTTR_LANES-1:0] next_valid;
  logic [`RTTR_LANES*`RTTR_ORDER_W-1:0] next_trace_order;
  logic sel_found;
  rttr_pkg::rttr_trap_t sel_trap;
  rttr_pkg::rttr_kind_e sel_kind;
  logic [`RTTR_PC_W-1:0] sel_pc;
  logic sel_upd_trap;
  logic sel_upd_debug;

  always_comb begin
    next_order = order;
    next_valid = '0;
    next_trace_order = '0;
    sel_found = 1'b0;
    sel_trap = '0;
    sel_kind = rttr_pkg::RTTR_KIND_NONE;
    sel_pc = '0;
    sel_upd_trap = 1'b0;
    sel_upd_debug = 1'b0;
    for (int i = 0; i < `RTTR_LANES; i++) begin
      if (lane_retire[i] && !sel_found) begin
        next_valid[i] = 1'b1;
        next_trace_order[i*`RTTR_ORDER_W +: `RTTR_ORDER_W] = next_order;
        next_order = next_order + `RTTR_ORDER_W'(1);
        if (lane_trap[i][`RTTR_F_TRAP]) begin
          sel_found = 1'b1;
          sel_trap = lane_trap[i];
          sel_kind = lane_kind[i];
          sel_pc = lane_pc[i*`RTTR_PC_W +: `RTTR_PC_W];
          sel_upd_trap = lane_upd_trap[i];
          sel_upd_debug = lane_upd_debug[i];
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      order <= '0;
    end else begin
      order <= next_order;
    end
  end

  // ----------------------------------------------------------------
  // Trace outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      trace_valid <= '0;
    end else begin
      trace_valid <= next_valid;
    end
  end

  // Payload is loaded only with a record, so idle cycles hold stale data
  // that the consumer is required to ignore.
  generate
    for (g = 0; g < `RTTR_LANES; g++) begin : g_payload
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          trace_order[g*`RTTR_ORDER_W +: `RTTR_ORDER_W] <= '0;
          trace_trap[g*`RTTR_TRAP_W +: `RTTR_TRAP_W] <= '0;
          trace_pc[g*`RTTR_PC_W +: `RTTR_PC_W] <= '0;
        end else if (next_valid[g]) begin
          trace_order[g*`RTTR_ORDER_W +: `RTTR_ORDER_W] <=
            next_trace_order[g*`RTTR_ORDER_W +: `RTTR_ORDER_W];
          trace_trap[g*`RTTR_TRAP_W +: `RTTR_TRAP_W] <= lane_trap[g];
          trace_pc[g*`RTTR_PC_W +: `RTTR_PC_W] <= lane_pc[g*`RTTR_PC_W +: `RTTR_PC_W];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Trap side effects, one cycle behind the record
  // ----------------------------------------------------------------
  logic pend_valid;
  rttr_pkg::rttr_trap_t pend_trap;
  rttr_pkg::rttr_kind_e pend_kind;
  logic [`RTTR_PC_W-1:0] pend_pc;
  logic pend_upd_trap;
  logic pend_upd_debug;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_valid <= 1'b0;
      pend_trap <= '0;
      pend_kind <= rttr_pkg::RTTR_KIND_NONE;
      pend_pc <= '0;
      pend_upd_trap <= 1'b0;
      pend_upd_debug <= 1'b0;
    end else begin
      pend_valid <= sel_found;
      pend_trap <= sel_trap;
      pend_kind <= sel_kind;
      pend_pc <= sel_pc;
      pend_upd_trap <= sel_found && sel_upd_trap;
      pend_upd_debug <= sel_found && sel_upd_debug;
    end
  end

  logic [5:0] trap_cause;
  logic [`RTTR_PC_W-1:0] trap_pc;
  logic [`RTTR_PC_W-1:0] debug_pc;
  logic [2:0] debug_status;
  rttr_pkg::rttr_trap_t last_trap;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      trap_cause <= '0;
      trap_pc <= '0;
    end else if (pend_upd_trap) begin
      trap_cause <= pend_trap[`RTTR_F_CODE_HI:`RTTR_F_CODE_LO];
      trap_pc <= pend_pc;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      debug_pc <= '0;
      debug_status <= `RTTR_DC_NONE;
    end else if (pend_upd_debug) begin
      debug_pc <= pend_pc;
      debug_status <= pend_trap[`RTTR_F_DCAUSE_HI:`RTTR_F_DCAUSE_LO];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      last_trap <= '0;
    end else if (pend_valid) begin
      last_trap <= pend_trap;
    end
  end

  // Debug-mode exceptions and breakpoints go to the debug handler and update
  // only the last trap register.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      trap_csr_wr <= 1'b0;
      debug_csr_wr <= 1'b0;
      jump_trap_handler <= 1'b0;
      jump_debug_handler <= 1'b0;
    end else begin
      trap_csr_wr <= pend_upd_trap;
      debug_csr_wr <= pend_upd_debug;
      jump_trap_handler <= pend_upd_trap && (pend_kind == rttr_pkg::RTTR_KIND_EXC);
      jump_debug_handler <= pend_valid && !(pend_upd_trap
                            && (pend_kind == rttr_pkg::RTTR_KIND_EXC));
    end
  end

  // ----------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------
  logic [31:0] next_rdata;

  always_comb begin
    next_rdata = 32'h0000_0000;
    case (reg_addr)
      `RTTR_A_CTRL: next_rdata = {30'h0000_0000, ctrl};
      `RTTR_A_ORDER_LO: next_rdata = order[31:0];
      `RTTR_A_ORDER_HI: next_rdata = order[63:32];
      `RTTR_A_TRAP_CAUSE: next_rdata = {26'h000_0000, trap_cause};
      `RTTR_A_TRAP_PC: next_rdata = trap_pc;
      `RTTR_A_DEBUG_PC: next_rdata = debug_pc;
      `RTTR_A_DEBUG_STATUS: next_rdata = {29'h0000_0000, debug_status};
      `RTTR_A_LAST_TRAP: next_rdata = {18'h0_0000, last_trap};
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

endmodule : rttr_top

// ---- src/rttr_trap_encode.sv ----
// Combinational encoder of one lane's synchronous trap record.
`include "rttr_defs.svh"

module rttr_trap_encode (
  input wire logic in_debug,
  input wire logic user_mode,
  input wire logic ebreak_to_debug,
  input wire logic step_enable,
  input wire logic ev_fetch_pma,
  input wire logic ev_fetch_pmp,
  input wire logic ev_fetch_bus,
  input wire logic ev_fetch_integrity,
  input wire logic ev_illegal,
  input wire logic ev_ebreak,
  input wire logic ev_ecall,
  input wire logic ev_load_io,
  input wire logic ev_load_pmp,
  input wire logic ev_store_io,
  input wire logic ev_store_pmp,
  input wire logic ev_trigger,
  output rttr_pkg::rttr_trap_t trap,
  output rttr_pkg::rttr_kind_e kind,
  output logic upd_trap_csr,
  output logic upd_debug_csr
);

  logic exc;
  logic dbg;
  logic [5:0] code;
  logic [2:0] dcause;
  logic [1:0] sub;

  always_comb begin
    exc = 1'b1;
    dbg = 1'b0;
    code = 6'h00;
    dcause = `RTTR_DC_NONE;
    sub = `RTTR_SUB_0;
    kind = rttr_pkg::RTTR_KIND_EXC;
    // A before-execution trigger wins outside debug mode, since the instruction never runs.
    if (ev_trigger && !in_debug) begin
      exc = 1'b0; dbg = 1'b1; dcause = `RTTR_DC_TRIGGER;
    end else if (ev_fetch_pma) begin
      code = `RTTR_EC_FETCH_ACCESS; sub = `RTTR_SUB_0;
    end else if (ev_fetch_pmp) begin
      code = `RTTR_EC_FETCH_ACCESS; sub = `RTTR_SUB_1;
    end else if (ev_fetch_bus) begin
      code = `RTTR_EC_FETCH_BUS;
    end else if (ev_fetch_integrity) begin
      code = `RTTR_EC_FETCH_INTEGRITY;
    end else if (ev_illegal) begin
      code = `RTTR_EC_ILLEGAL;
    end else if (ev_ebreak && in_debug) begin
      exc = 1'b0; dbg = 1'b1; dcause = `RTTR_DC_EBREAK;
    end else if (ev_ebreak && ebreak_to_debug) begin
      exc = 1'b0; dbg = 1'b1; dcause = `RTTR_DC_EBREAK;
    end else if (ev_ebreak) begin
      code = `RTTR_EC_BREAKPOINT;
    end else if (ev_ecall) begin
      code = user_mode ? `RTTR_EC_ECALL_USER : `RTTR_EC_ECALL_MACHINE;
    end else if (ev_load_io || ev_load_pmp) begin
      code = `RTTR_EC_LOAD_ACCESS;
      sub = ev_load_io ? `RTTR_SUB_0 : `RTTR_SUB_2;
    end else if (ev_store_io || ev_store_pmp) begin
      code = `RTTR_EC_STORE_ACCESS;
      sub = ev_store_io ? `RTTR_SUB_0 : `RTTR_SUB_2;
    end else begin
      exc = 1'b0;
    end
    if (dbg) begin
      kind = in_debug ? rttr_pkg::RTTR_KIND_DEBUG_STAY : rttr_pkg::RTTR_KIND_DEBUG;
    end else if (step_enable && !in_debug) begin
      dbg = 1'b1; dcause = `RTTR_DC_STEP; kind = rttr_pkg::RTTR_KIND_DEBUG;
    end else if (!exc) begin
      kind = rttr_pkg::RTTR_KIND_NONE;
    end
    upd_trap_csr = exc && !in_debug;
    upd_debug_csr = dbg && !in_debug;
    trap = '0;
    trap[`RTTR_F_TRAP] = exc || dbg;
    trap[`RTTR_F_EXC] = exc;
    trap[`RTTR_F_DBG] = dbg;
    trap[`RTTR_F_CODE_HI:`RTTR_F_CODE_LO] = code;
    trap[`RTTR_F_DCAUSE_HI:`RTTR_F_DCAUSE_LO] = dcause;
    trap[`RTTR_F_SUB_HI:`RTTR_F_SUB_LO] = sub;
  end

endmodule : rttr_trap_encode

// ---- tb/retire_trace_trap_report_bench.sv ----
// Self-checking bench of the retire trace and trap report block.
`include "rttr_defs.svh"
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin miscompares++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end

module retire_trace_trap_report_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic in_debug = 1'b0;
  logic user_mode = 1'b0;
  logic step_enable = 1'b0;
  logic [1:0] lane_retire = 2'h0;
  logic [63:0] lane_pc = 64'h0;
  logic [1:0] ev [12] = '{default: 2'h0};
  logic [31:0] reg_rdata;
  logic [1:0] trace_valid;
  logic [127:0] trace_order;
  logic [27:0] trace_trap;
  logic [63:0] trace_pc;
  logic trap_csr_wr, debug_csr_wr, jt, jd, order_err;
  logic [3:0] side;
  logic [31:0] p;
  logic [63:0] o0;
  logic [63:0] ord = 64'h0;
  int miscompares = 0;
  int check_count = 0;
  int cyc = 0;
  // Event order: pma, pmp, bus, integrity, illegal, ebreak, ecall, load io/pmp, store io/pmp.
  logic [5:0] codes [11] = '{6'h01, 6'h01, 6'h24, 6'h25, 6'h02, 6'h03, 6'h08, 6'h05, 6'h05,
    6'h07, 6'h07};
  logic [1:0] subs [11] = '{2'h0, 2'h1, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h2, 2'h0, 2'h2};
  assign side = {trap_csr_wr, jt, debug_csr_wr, jd};

  always #25 clk = ~clk;

  rttr_top rttr_top_i (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .in_debug(in_debug),
    .user_mode(user_mode), .step_enable(step_enable), .lane_retire(lane_retire),
    .lane_pc(lane_pc), .ev_fetch_pma(ev[0]), .ev_fetch_pmp(ev[1]), .ev_fetch_bus(ev[2]),
    .ev_fetch_integrity(ev[3]), .ev_illegal(ev[4]), .ev_ebreak(ev[5]), .ev_ecall(ev[6]),
    .ev_load_io(ev[7]), .ev_load_pmp(ev[8]), .ev_store_io(ev[9]), .ev_store_pmp(ev[10]),
    .ev_trigger(ev[11]), .trace_valid(trace_valid), .trace_order(trace_order),
    .trace_trap(trace_trap), .trace_pc(trace_pc), .trap_csr_wr(trap_csr_wr),
    .debug_csr_wr(debug_csr_wr), .jump_trap_handler(jt), .jump_debug_handler(jd));

  rttr_trace_sink rttr_trace_sink_i (.clk(clk), .rst_n(rst_n), .trace_valid(trace_valid),
    .trace_order(trace_order), .order_err(order_err));

  task automatic finish_test();
    if (miscompares == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : finish_test

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      miscompares++;
      finish_test();
    end
  end

  task automatic step1();
    @(posedge clk);
    #1;
  endtask : step1

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    `CHK(reg_rdata, e);
  endtask : rdchk

  // Presents one instruction per chosen lane; k0 and k1 pick the event, 12 means none.
  task automatic fire(input logic [1:0] ln, input int k0, input int k1);
    @(posedge clk);
    p = 32'h0000_1000 + ord[31:0];
    o0 = ord;
    lane_retire <= ln;
    lane_pc <= {p + 32'h0000_0004, p};
    for (int i = 0; i < 12; i++) ev[i] <= {i == k1, i == k0};
    @(posedge clk);
    lane_retire <= 2'h0;
    for (int i = 0; i < 12; i++) ev[i] <= 2'h0;
    #1;
    `CHK(trace_valid[0], 1'b1);
    `CHK(trace_order[63:0], o0);
    `CHK(trace_pc[31:0], p);
    ord = ord + ((ln == 2'h3 && k0 == 12) ? 64'h2 : 64'h1);
  endtask : fire

  task automatic t_regs();
    rdchk(`RTTR_A_ORDER_LO, 32'h0);
    rdchk(`RTTR_A_ORDER_HI, 32'h0);
    rdchk(8'h20, 32'h0);
    wr(8'h20, 32'h0000_0003);
    rdchk(`RTTR_A_CTRL, 32'h0);
  endtask : t_regs

  task automatic t_order();
    fire(2'h3, 12, 12);
    `CHK(trace_valid, 2'h3);
    `CHK(trace_order[127:64], o0 + 64'h1);
    `CHK(trace_pc[63:32], p + 32'h0000_0004);
    `CHK(trace_trap, 28'h0);
    fire(2'h3, 4, 12);
    `CHK(trace_valid, 2'h1);
  endtask : t_order

  task automatic t_exc();
    user_mode <= 1'b1;
    for (int k = 0; k < 11; k++) begin
      fire(2'h1, k, 12);
      `CHK(trace_trap[13:0], {subs[k], 3'h0, codes[k], 3'h3});
      step1();
      `CHK(side, 4'hC);
      rdchk(`RTTR_A_TRAP_CAUSE, {26'h0, codes[k]});
      rdchk(`RTTR_A_TRAP_PC, p);
    end
    user_mode <= 1'b0;
    fire(2'h1, 6, 12);
    `CHK(trace_trap[13:0], {2'h0, 3'h0, 6'h0b, 3'h3});
  endtask : t_exc

  task automatic t_debug();
    wr(`RTTR_A_CTRL, 32'h0000_0001);
    fire(2'h1, 5, 12);
    `CHK({trace_trap[11:9], trace_trap[2:0]}, 6'h0D);
    step1();
    `CHK(side, 4'h3);
    rdchk(`RTTR_A_DEBUG_PC, p);
    rdchk(`RTTR_A_DEBUG_STATUS, 32'h1);
    fire(2'h1, 11, 12);
    `CHK({trace_trap[11:9], trace_trap[2:0]}, 6'h15);
    step1();
    `CHK(side, 4'h3);
    rdchk(`RTTR_A_DEBUG_STATUS, 32'h2);
    in_debug <= 1'b1;
    fire(2'h1, 5, 12);
    `CHK({trace_trap[11:9], trace_trap[2:0]}, 6'h0D);
    step1();
    `CHK(side, 4'h1);
    rdchk(`RTTR_A_DEBUG_STATUS, 32'h2);
    in_debug <= 1'b0;
  endtask : t_debug

  task automatic t_step();
    step_enable <= 1'b1;
    fire(2'h1, 12, 12);
    `CHK({trace_trap[11:9], trace_trap[2:0]}, 6'h25);
    step1();
    `CHK(side, 4'h3);
    fire(2'h1, 4, 12);
    `CHK(trace_trap[11:0], {3'h4, 6'h02, 3'h7});
    step1();
    `CHK(side, 4'hB);
    rdchk(`RTTR_A_LAST_TRAP, {18'h0, 2'h0, 3'h4, 6'h02, 3'h7});
    step_enable <= 1'b0;
  endtask : t_step

  task automatic t_rerst();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    ord = 64'h0;
    fire(2'h1, 12, 12);
    `CHK(trace_order[63:0], 64'h0);
  endtask : t_rerst

  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_order();
    t_exc();
    t_debug();
    t_step();
    `CHK(order_err, 1'b0);
    t_rerst();
    step1();
    `CHK(order_err, 1'b0);
    finish_test();
  end
endmodule : retire_trace_trap_report_bench

// ---- tb/rttr_top_sva.sv ----
// Assertion checker bound to the retire trace and trap report top.
module rttr_top_chk (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_debug,
  input wire logic step_enable,
  input wire logic [1:0] lane_retire,
  input wire logic [1:0] ev_fetch_pma,
  input wire logic [1:0] ev_fetch_pmp,
  input wire logic [1:0] ev_fetch_bus,
  input wire logic [1:0] ev_fetch_integrity,
  input wire logic [1:0] ev_illegal,
  input wire logic [1:0] ev_ebreak,
  input wire logic [1:0] ev_ecall,
  input wire logic [1:0] ev_load_io,
  input wire logic [1:0] ev_load_pmp,
  input wire logic [1:0] ev_store_io,
  input wire logic [1:0] ev_store_pmp,
  input wire logic [1:0] ev_trigger,
  input wire logic [1:0] trace_valid,
  input wire logic [127:0] trace_order,
  input wire logic [27:0] trace_trap,
  input wire logic trap_csr_wr,
  input wire logic debug_csr_wr,
  input wire logic jump_trap_handler,
  input wire logic jump_debug_handler
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [11:0] ev0;
  logic [5:0] dbg0;
  assign ev0 = {ev_trigger[0], ev_store_pmp[0], ev_store_io[0], ev_load_pmp[0], ev_load_io[0],
    ev_ecall[0], ev_ebreak[0], ev_illegal[0], ev_fetch_integrity[0], ev_fetch_bus[0],
    ev_fetch_pmp[0], ev_fetch_pma[0]};
  // Debug records leave the code field open, so only cause and flags are compared.
  assign dbg0 = {trace_trap[11:9], trace_trap[2:0]};

  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  AST_VALID_LAT: assert property (lane_retire[0] |=> trace_valid[0])
    else $error("lane 0 record missing");
  AST_IDLE: assert property (!lane_retire[0] |=> !trace_valid[0])
    else $error("lane 0 record without retirement");
  AST_DROP: assert property (lane_retire == 2'h3
    && (ev0[10:0] != 11'h000 || (ev0[11] && !in_debug)) |=> trace_valid == 2'h1)
    else $error("lane 1 not dropped behind a trap");
  AST_ORDER_PAIR: assert property (trace_valid == 2'h3 |->
    trace_order[127:64] == trace_order[63:0] + 64'h1)
    else $error("lane orders not consecutive");
  AST_TRAP_FLAG: assert property (trace_valid[0] && (|trace_trap[2:1]) |-> trace_trap[0])
    else $error("trap flag missing");
  AST_TRAP_SIDE: assert property (trace_valid[0] && trace_trap[2:0] == 3'h3
    && !$past(in_debug) |=> trap_csr_wr && jump_trap_handler)
    else $error("trap side effects missing");
  AST_ILLEGAL: assert property (lane_retire[0] && ev0 == 12'h010
    && !in_debug && !step_enable |=> trace_trap[13:0] == 14'h0013)
    else $error("illegal record wrong");
  AST_FETCH_PMP: assert property (lane_retire[0] && ev0 == 12'h002
    && !in_debug && !step_enable |=> trace_trap[13:0] == 14'h100B)
    else $error("fetch protection record wrong");
  AST_EBRK_IN_DBG: assert property (lane_retire[0] && ev0 == 12'h020 && in_debug
    |=> dbg0 == 6'h0D ##1 jump_debug_handler && !trap_csr_wr && !debug_csr_wr)
    else $error("breakpoint in debug wrong");
  AST_STEP: assert property (lane_retire[0] && ev0 == 12'h000 && step_enable && !in_debug
    |=> dbg0 == 6'h25 ##1 debug_csr_wr && jump_debug_handler)
    else $error("single step record wrong");
  AST_TRIGGER: assert property (lane_retire[0] && ev0 == 12'h800
    && !in_debug && !step_enable |=> dbg0 == 6'h15 ##1 debug_csr_wr && !trap_csr_wr)
    else $error("trigger record wrong");

  COV_DUAL: cover property (trace_valid == 2'h3);
  COV_BOTH_CSR: cover property (trap_csr_wr && debug_csr_wr);
  COV_DBG_STAY: cover property (jump_debug_handler && !debug_csr_wr);
endmodule : rttr_top_chk

bind rttr_top rttr_top_chk rttr_top_chk_i (.clk(clk), .rst_n(rst_n), .in_debug(in_debug),
  .step_enable(step_enable), .lane_retire(lane_retire), .ev_fetch_pma(ev_fetch_pma),
  .ev_fetch_pmp(ev_fetch_pmp), .ev_fetch_bus(ev_fetch_bus),
  .ev_fetch_integrity(ev_fetch_integrity), .ev_illegal(ev_illegal), .ev_ebreak(ev_ebreak),
  .ev_ecall(ev_ecall), .ev_load_io(ev_load_io), .ev_load_pmp(ev_load_pmp),
  .ev_store_io(ev_store_io), .ev_store_pmp(ev_store_pmp), .ev_trigger(ev_trigger),
  .trace_valid(trace_valid), .trace_order(trace_order), .trace_trap(trace_trap),
  .trap_csr_wr(trap_csr_wr), .debug_csr_wr(debug_csr_wr),
  .jump_trap_handler(jump_trap_handler), .jump_debug_handler(jump_debug_handler));

// ---- tb/rttr_trace_sink.sv ----
// Trace consumer model that follows the order sequence of valid records.
module rttr_trace_sink (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [1:0] trace_valid,
  input wire logic [127:0] trace_order,
  output logic order_err
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [63:0] exp_order;
  logic [63:0] exp_one;
  assign exp_one = exp_order + {63'h0, trace_valid[0]};
  // Fields are looked at only under valid; whatever stands otherwise is ignored.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      exp_order <= 64'h0;
      order_err <= 1'b0;
    end else begin
      if (trace_valid[0] && trace_order[63:0] !== exp_order) order_err <= 1'b1;
      if (trace_valid[1] && trace_order[127:64] !== exp_one) order_err <= 1'b1;
      exp_order <= exp_one + {63'h0, trace_valid[1]};
    end
  end
endmodule : rttr_trace_sink
